/* hw/tcu8_pkg.sv */
// Purpose: Shared constants for the eight-bit timer/counter compare unit
// Assumes: Wishbone classic slave, 32-bit data, 8-bit registers in lane 0
// Notes:   Byte offsets are word aligned; upper data bits read as zero
package tcu8_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFS_COUNTER_VALUE     = 8'h04;
  localparam logic [7:0] OFS_COMPARE_VALUE     = 8'h08;
  localparam logic [7:0] OFS_FLAGS             = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLE        = 8'h10;
  localparam logic [7:0] OFS_PORT              = 8'h14;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CTL_CS_LSB   = 0;  // clock_source_select [2:0]
  localparam int CTL_WGM_LSB  = 3;  // waveform_mode [4:3]
  localparam int CTL_COM_LSB  = 5;  // compare_output_mode [6:5]
  localparam int CTL_FOC_BIT  = 7;  // force_compare_strobe, reads 0
  localparam int FLG_OVF_BIT  = 0;  // overflow_flag
  localparam int FLG_OCF_BIT  = 1;  // compare_match_flag
  localparam int PRT_VAL_BIT  = 0;  // general port output value
  localparam int PRT_DIR_BIT  = 1;  // output_pin_direction

  // ---------------------------------------------------------------------
  // Reset values and counter limits
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;

  // Waveform modes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE  = 2'h1;
  localparam logic [1:0] WGM_CTC    = 2'h2;
  localparam logic [1:0] WGM_FAST   = 2'h3;

  // Compare output modes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Clock source codes
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler width (divide by up to 1024)
  localparam int PRE_W = 10;

endpackage : tcu8_pkg

/* hw/tcu8_timer.sv */
// Purpose: Eight-bit timer/counter with one compare unit and output stage
// Assumes: One 250 MHz clock, synchronous active-high reset, inputs
//          synchronous to clk_i, Wishbone classic register access
// Notes:   Notes on behaviour follow
// Notes on behaviour
// [RULE1] Clock select zero stops ticks, counter holds
// [RULE2] CPU counter write beats clear or count
// [RULE3] Counter readable and writable at any time
// [RULE4] Each tick clears, increments or decrements counter
// [RULE5] Mode picks sequence; overflow flag may interrupt
// [RULE6] Comparator flags counter equal to compare value
// [RULE7] Match sets compare flag on next tick
// [RULE8] Compare interrupt needs enable and global enable
// [RULE9] Compare flag clears on service or write-one
// [RULE10] Compare value buffered only in PWM modes
// [RULE11] Buffer transfers at top or bottom only
// [RULE12] CPU reaches buffer when buffered, else active
// [RULE13] Force strobe acts like match, no flag
// [RULE14] Counter write blocks matches for next tick
// [RULE15] Output register kept across mode changes
// [RULE16] Output mode change applies at next match
// [RULE17] Reset clears internal compare output register
// [RULE18] Nonzero output mode overrides general port value
// [RULE19] Output reaches pin only when direction output
// [RULE20] Output mode zero leaves output register unchanged
// [RULE21] Max and bottom handle extreme compare values
// [RULE22] Software avoids writing counter to match value
// [RULE23] Bottom indication when counter is 0x00
// [RULE24] Max indication when counter is 0xFF
// [RULE25] Nonzero selects prescaled clock or pin edge
module tcu8_timer (
  input  wire logic        clk_i,           // System clock, 250 MHz
  input  wire logic        rst_i,           // Sync reset, active high
  input  wire logic        cyc_i,           // Wishbone cycle
  input  wire logic        stb_i,           // Wishbone strobe
  input  wire logic        we_i,            // Wishbone write enable
  input  wire logic [7:0]  adr_i,           // Wishbone byte address
  input  wire logic [3:0]  sel_i,           // Wishbone byte selects
  input  wire logic [31:0] dat_i,           // Wishbone write data
  output logic      [31:0] dat_o,           // Wishbone read data
  output logic             ack_o,           // Wishbone acknowledge
  input  wire logic        ext_clk_i,       // External counter pin
  input  wire logic        global_irq_en_i, // CPU status global enable
  input  wire logic        ovf_irq_ack_i,   // Overflow irq serviced
  input  wire logic        cmp_irq_ack_i,   // Compare irq serviced
  output logic             ovf_irq_o,       // Overflow irq request
  output logic             cmp_irq_o,       // Compare irq request
  output logic             pin_o,           // Pin output level
  output logic             pin_oe_o         // Pin output enable
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 cnt;
    logic                       down;
    logic [7:0]                 ocr_act;
    logic [7:0]                 ocr_buf;
    logic [2:0]                 cs;
    logic [1:0]                 wgm;
    logic [1:0]                 com;
    logic                       ovf;
    logic                       ocf;
    logic                       ovf_ie;
    logic                       ocf_ie;
    logic                       port_val;
    logic                       ddr;
    logic                       oc;
    logic                       block;
    logic [tcu8_pkg::PRE_W-1:0] pre;
    logic                       ext_q;
    logic                       ack;
    logic [7:0]                 dat;
    logic                       irq_ovf;
    logic                       irq_cmp;
    logic                       pin;
    logic                       oe;
  } tcu8_state_s;

  tcu8_state_s q_r;
  tcu8_state_s d_nxt;

  // PWM modes use the buffered compare value
  function automatic logic tcu8_is_pwm(input logic [1:0] wgm);
    tcu8_is_pwm = (wgm == tcu8_pkg::WGM_FAST) ||
                  (wgm == tcu8_pkg::WGM_PHASE);
  endfunction

  // Compare output action applied to the output register
  function automatic logic tcu8_apply(input logic [1:0] com,
                                      input logic       oc,
                                      input logic       inv);
    case (com)
      tcu8_pkg::COM_TOGGLE: tcu8_apply = ~oc;
      tcu8_pkg::COM_CLEAR:  tcu8_apply = inv;
      tcu8_pkg::COM_SET:    tcu8_apply = ~inv;
      default:              tcu8_apply = oc;
    endcase
  endfunction

  // -----------------------------------------------------------------------
  // Bus decode and tick generation
  // -----------------------------------------------------------------------
  logic       bus_wr;
  logic       wr_ctl;
  logic       wr_cnt;
  logic       wr_ocr;
  logic [7:0] wdat;
  logic       tick;
  logic       is_bottom;
  logic       is_max;
  logic       match;

  // Write lands at the edge where the master sees ack high
  assign bus_wr = cyc_i && stb_i && we_i && q_r.ack && sel_i[0];
  assign wr_ctl = bus_wr && (adr_i == tcu8_pkg::OFS_TIMER_CONTROL_REG);
  assign wr_cnt = bus_wr && (adr_i == tcu8_pkg::OFS_COUNTER_VALUE);
  assign wr_ocr = bus_wr && (adr_i == tcu8_pkg::OFS_COMPARE_VALUE);
  assign wdat   = dat_i[7:0];

  assign is_bottom = (q_r.cnt == tcu8_pkg::CNT_BOTTOM);   // [RULE23]
  assign is_max    = (q_r.cnt == tcu8_pkg::CNT_MAX);      // [RULE24]
  assign match     = (q_r.cnt == q_r.ocr_act);            // [RULE6]

  // Tick source select; prescaler runs free so ratios stay exact
  always_comb begin
    case (q_r.cs)                                         // [RULE25]
      tcu8_pkg::CS_DIV1:     tick = 1'b1;
      tcu8_pkg::CS_DIV8:     tick = (q_r.pre[2:0] == 3'h7);
      tcu8_pkg::CS_DIV64:    tick = (q_r.pre[5:0] == 6'h3F);
      tcu8_pkg::CS_DIV256:   tick = (q_r.pre[7:0] == 8'hFF);
      tcu8_pkg::CS_DIV1024:  tick = (q_r.pre == 10'h3FF);
      tcu8_pkg::CS_EXT_FALL: tick = q_r.ext_q && !ext_clk_i;
      tcu8_pkg::CS_EXT_RISE: tick = !q_r.ext_q && ext_clk_i;
      default:               tick = 1'b0;                 // [RULE1]
    endcase
  end

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  always_comb begin
    logic       pwm;
    logic       hit;
    logic       set_ovf;
    logic       set_ocf;
    logic [7:0] rd;
    pwm     = tcu8_is_pwm(q_r.wgm);
    hit     = tick && match && !q_r.block;                // [RULE14]
    set_ovf = 1'b0;
    set_ocf = 1'b0;
    rd      = tcu8_pkg::RST_BYTE;
    d_nxt   = q_r;
    d_nxt.pre   = q_r.pre + 10'h001;
    d_nxt.ext_q = ext_clk_i;

    // Counting sequence per waveform mode
    if (tick) begin                                       // [RULE4]
      case (q_r.wgm)                                      // [RULE5]
        tcu8_pkg::WGM_CTC: begin
          d_nxt.cnt = match ? tcu8_pkg::CNT_BOTTOM : q_r.cnt + 8'h01;
          set_ovf   = is_max;
        end
        tcu8_pkg::WGM_PHASE: begin
          // Direction turns at max and bottom
          if (is_max) begin                               // [RULE21]
            d_nxt.down = 1'b1;
            d_nxt.cnt  = q_r.cnt - 8'h01;
          end else if (is_bottom) begin
            d_nxt.down = 1'b0;
            d_nxt.cnt  = q_r.cnt + 8'h01;
          end else begin
            d_nxt.cnt  = q_r.down ? q_r.cnt - 8'h01 : q_r.cnt + 8'h01;
          end
          set_ovf = is_bottom;
        end
        default: begin
          d_nxt.down = 1'b0;
          d_nxt.cnt  = q_r.cnt + 8'h01;
          set_ovf    = is_max;
        end
      endcase
      set_ocf     = hit;                                  // [RULE7]
      d_nxt.block = 1'b0;
    end

    // Buffered compare value moves at max in both PWM modes
    if (tick && pwm) begin                                // [RULE11]
      if ((q_r.wgm == tcu8_pkg::WGM_FAST && is_max) ||
          (q_r.wgm == tcu8_pkg::WGM_PHASE && is_max)) begin
        d_nxt.ocr_act = q_r.ocr_buf;
      end
    end

    // Output register actions; mode bits read live, not buffered
    if (hit) begin                                        // [RULE16]
      case (q_r.wgm)
        tcu8_pkg::WGM_PHASE:
          d_nxt.oc = tcu8_apply(q_r.com, q_r.oc,
                                q_r.down && !is_max);     // [RULE21]
        default:
          d_nxt.oc = tcu8_apply(q_r.com, q_r.oc, 1'b0);   // [RULE20]
      endcase
    end
    // Fast PWM: opposite action at bottom; max compare gives steady level
    if (tick && q_r.wgm == tcu8_pkg::WGM_FAST && is_max &&
        q_r.com[1]) begin                                 // [RULE21]
      d_nxt.oc = tcu8_apply(q_r.com, q_r.oc, 1'b1);
    end

    // Flag set wins over any clear in the same cycle
    if (cmp_irq_ack_i) d_nxt.ocf = 1'b0;                  // [RULE9]
    if (ovf_irq_ack_i) d_nxt.ovf = 1'b0;
    if (bus_wr && adr_i == tcu8_pkg::OFS_FLAGS) begin
      if (wdat[tcu8_pkg::FLG_OCF_BIT]) d_nxt.ocf = 1'b0;  // [RULE9]
      if (wdat[tcu8_pkg::FLG_OVF_BIT]) d_nxt.ovf = 1'b0;
    end
    if (set_ocf) d_nxt.ocf = 1'b1;
    if (set_ovf) d_nxt.ovf = 1'b1;                        // [RULE5]

    // Register writes
    if (wr_ctl) begin
      d_nxt.cs  = wdat[tcu8_pkg::CTL_CS_LSB +: 3];
      d_nxt.wgm = wdat[tcu8_pkg::CTL_WGM_LSB +: 2];       // [RULE15]
      d_nxt.com = wdat[tcu8_pkg::CTL_COM_LSB +: 2];
      // Force acts with the mode bits already in place
      if (wdat[tcu8_pkg::CTL_FOC_BIT] && !pwm)            // [RULE13]
        d_nxt.oc = tcu8_apply(q_r.com, q_r.oc, 1'b0);
    end
    if (wr_cnt) begin                                     // [RULE2]
      d_nxt.cnt   = wdat;                                 // [RULE3]
      d_nxt.block = 1'b1;                                 // [RULE14]
    end
    if (wr_ocr) begin                                     // [RULE12]
      d_nxt.ocr_buf = wdat;
      if (!pwm) d_nxt.ocr_act = wdat;                     // [RULE10]
    end
    if (bus_wr && adr_i == tcu8_pkg::OFS_IRQ_ENABLE) begin
      d_nxt.ovf_ie = wdat[tcu8_pkg::FLG_OVF_BIT];
      d_nxt.ocf_ie = wdat[tcu8_pkg::FLG_OCF_BIT];
    end
    if (bus_wr && adr_i == tcu8_pkg::OFS_PORT) begin
      d_nxt.port_val = wdat[tcu8_pkg::PRT_VAL_BIT];
      d_nxt.ddr      = wdat[tcu8_pkg::PRT_DIR_BIT];
    end

    // Read mux; unmapped addresses read zero
    case (adr_i)
      tcu8_pkg::OFS_TIMER_CONTROL_REG: rd = {1'b0, q_r.com, q_r.wgm, q_r.cs};
      tcu8_pkg::OFS_COUNTER_VALUE:     rd = q_r.cnt;      // [RULE3]
      tcu8_pkg::OFS_COMPARE_VALUE:
        rd = pwm ? q_r.ocr_buf : q_r.ocr_act;             // [RULE12]
      tcu8_pkg::OFS_FLAGS:      rd = {6'h00, q_r.ocf, q_r.ovf};
      tcu8_pkg::OFS_IRQ_ENABLE: rd = {6'h00, q_r.ocf_ie, q_r.ovf_ie};
      tcu8_pkg::OFS_PORT:       rd = {6'h00, q_r.ddr, q_r.port_val};
      default:                  rd = tcu8_pkg::RST_BYTE;
    endcase
    d_nxt.ack = cyc_i && stb_i && !q_r.ack;
    if (cyc_i && stb_i && !q_r.ack) d_nxt.dat = rd;

    // Interrupt requests gated by the CPU global enable
    d_nxt.irq_cmp = d_nxt.ocf && d_nxt.ocf_ie && global_irq_en_i; // [RULE8]
    d_nxt.irq_ovf = d_nxt.ovf && d_nxt.ovf_ie && global_irq_en_i; // [RULE5]

    // Pin override and direction
    d_nxt.pin = (d_nxt.com != tcu8_pkg::COM_OFF) ? d_nxt.oc
                                                 : d_nxt.port_val; // [RULE18]
    d_nxt.oe  = d_nxt.ddr;                                // [RULE19]
  end

  // State register; reset clears the output register among the rest
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;                                          // [RULE17]
    end else begin
      q_r <= d_nxt;
    end
  end

  assign dat_o     = {24'h000000, q_r.dat};
  assign ack_o     = q_r.ack;
  assign ovf_irq_o = q_r.irq_ovf;
  assign cmp_irq_o = q_r.irq_cmp;
  assign pin_o     = q_r.pin;
  assign pin_oe_o  = q_r.oe;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_stop_hold;
    (q_r.cs == tcu8_pkg::CS_STOP) && !wr_cnt |=> q_r.cnt == $past(q_r.cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold)                // [RULE1]
    else $error("counter moved with clock stopped");

  property p_cnt_write;
    wr_cnt |=> q_r.cnt == $past(wdat) && q_r.block;
  endproperty
  a_cnt_write: assert property (p_cnt_write)                // [RULE2]
    else $error("counter write lost");

  property p_count_up;
    tick && !wr_cnt && q_r.wgm == tcu8_pkg::WGM_NORMAL
      |=> q_r.cnt == $past(q_r.cnt) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up)                  // [RULE4]
    else $error("normal mode did not increment");

  property p_ovf_set;
    tick && is_max && q_r.wgm == tcu8_pkg::WGM_NORMAL |=> q_r.ovf;
  endproperty
  a_ovf_set: assert property (p_ovf_set)                    // [RULE5]
    else $error("overflow flag not set");

  property p_ocf_set;
    tick && match && !q_r.block |=> q_r.ocf;
  endproperty
  a_ocf_set: assert property (p_ocf_set)                    // [RULE7]
    else $error("compare flag not set on tick");

  // Helper: counter write stays pending until the next tick, so a
  // stopped timer keeps the block for as long as it stays stopped
  logic blk_seen_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_seen_r <= 1'b0;
    end else if (wr_cnt) begin
      blk_seen_r <= 1'b1;
    end else if (tick) begin
      blk_seen_r <= 1'b0;
    end
  end

  property p_block;
    tick && blk_seen_r && !q_r.ocf |=> !q_r.ocf;
  endproperty
  a_block: assert property (p_block)                        // [RULE14]
    else $error("match after counter write not blocked");

  property p_irq;
    cmp_irq_o |-> $past(q_r.ocf_ie) || q_r.ocf_ie;
  endproperty
  a_irq: assert property (p_irq)                            // [RULE8]
    else $error("compare irq without enable");

  property p_svc_clear;
    cmp_irq_ack_i && !(tick && match && !q_r.block) |=> !q_r.ocf;
  endproperty
  a_svc_clear: assert property (p_svc_clear)                // [RULE9]
    else $error("compare flag not cleared on service");

  property p_direct;
    wr_ocr && !tcu8_is_pwm(q_r.wgm) |=> q_r.ocr_act == $past(wdat);
  endproperty
  a_direct: assert property (p_direct)                      // [RULE10]
    else $error("unbuffered compare write not direct");

  property p_pin_dir;
    ##1 pin_oe_o == $past(q_r.ddr, 1) || $past(bus_wr);
  endproperty
  a_pin_dir: assert property (p_pin_dir)                    // [RULE19]
    else $error("pin enable does not follow direction");

  property p_reset_oc;
    disable iff (1'b0) rst_i |=> !q_r.oc && !pin_o;
  endproperty
  a_reset_oc: assert property (p_reset_oc)                  // [RULE17]
    else $error("output register not cleared by reset");

  c_ctc_wrap:  cover property (q_r.wgm == tcu8_pkg::WGM_CTC && tick && match);
  c_pwm_load:  cover property (q_r.wgm == tcu8_pkg::WGM_FAST && tick && is_max);
  c_phase_dn:  cover property (q_r.wgm == tcu8_pkg::WGM_PHASE && q_r.down);
  c_irq_cmp:   cover property (cmp_irq_o);

endmodule : tcu8_timer

/* verification/tcu8_cpu_model.sv */
// Purpose: CPU side that services timer interrupt requests
// Assumes: Requests are levels; service is a one-cycle pulse
// Notes:   lat_i sets service delay, so replies can be prompt or slow
module tcu8_cpu_model (
  input  wire logic       clk_i,     // System clock
  input  wire logic       rst_i,     // Sync reset, active high
  input  wire logic [3:0] lat_i,     // Cycles before servicing
  input  wire logic [1:0] irq_i,     // {compare, overflow} requests
  output logic      [1:0] irq_ack_o  // {compare, overflow} service
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] busy_r;
  logic [3:0] wait_r [2];

  // Service each request once; wait for its fall before the next
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      irq_ack_o[i] <= 1'b0;
      if (rst_i) begin
        busy_r[i] <= 1'b0;
        wait_r[i] <= 4'h0;
      end else if (busy_r[i]) begin
        busy_r[i] <= irq_i[i];
      end else if (irq_i[i]) begin
        wait_r[i] <= wait_r[i] + 4'h1;
        if (wait_r[i] == lat_i) begin
          irq_ack_o[i] <= 1'b1;
          busy_r[i]    <= 1'b1;
          wait_r[i]    <= 4'h0;
        end
      end
    end
  end
endmodule // tcu8_cpu_model

/* verification/tb.sv */
// Purpose: Self-checking bench for the timer/counter compare unit
// Assumes: External pin used as tick source for exact tick counts
// Notes:   Random counter and compare values from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic        ext_clk_i = 0, global_irq_en_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF, lat = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'h30D6;
  logic        ack_o, ovf_irq_o, cmp_irq_o, pin_o, pin_oe_o;
  logic [1:0]  svc;
  logic [7:0]  v;
  int          miscompares = 0, n_checks = 0, cycles = 0;

  tcu8_timer tcu8_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(ext_clk_i),
    .global_irq_en_i(global_irq_en_i), .ovf_irq_ack_i(svc[0]),
    .cmp_irq_ack_i(svc[1]), .ovf_irq_o(ovf_irq_o), .cmp_irq_o(cmp_irq_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  tcu8_cpu_model tcu8_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .lat_i(lat), .irq_i({cmp_irq_o, ovf_irq_o}), .irq_ack_o(svc));

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  end
  // Hang guard: run needs well under 5000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] ctl(logic [2:0] cs, logic [1:0] wgm,
                                     logic [1:0] com, logic foc);
    return {foc, com, wgm, cs};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    // No limit of its own; the watchdog ends a hung access
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  // n rising edges on the external counter pin, each followed by a fall
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_clk_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    chk(pin_o, 0);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    rc(8'h40, 8'h00);
    // Stopped timer: values hold and read back
    for (int i = 0; i < 8; i++) begin
      v = xs();
      wb(1, tcu8_pkg::OFS_COUNTER_VALUE, v);
      repeat (5) @(posedge clk_i);
      rc(tcu8_pkg::OFS_COUNTER_VALUE, v);
      wb(1, tcu8_pkg::OFS_COMPARE_VALUE, ~v);
      rc(tcu8_pkg::OFS_COMPARE_VALUE, ~v);
    end
    // Pin-edge ticks, match then flag one tick later
    wb(1, 8'h00, ctl(tcu8_pkg::CS_EXT_RISE, tcu8_pkg::WGM_NORMAL, 0, 0));
    wb(1, tcu8_pkg::OFS_COMPARE_VALUE, 8'h20);
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h1E);
    tick(1);
    rc(tcu8_pkg::OFS_COUNTER_VALUE, 8'h1F);
    tick(1);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    tick(1);
    rc(tcu8_pkg::OFS_FLAGS, 8'h02);
    wb(1, tcu8_pkg::OFS_IRQ_ENABLE, 8'h02);
    repeat (3) @(posedge clk_i);
    chk(cmp_irq_o, 0);
    global_irq_en_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(cmp_irq_o, 1);
    repeat (30) @(posedge clk_i);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    global_irq_en_i <= 1'b0;
    lat <= 4'h0;
    // Write-one clear
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h1F);
    tick(2);
    rc(tcu8_pkg::OFS_FLAGS, 8'h02);
    wb(1, tcu8_pkg::OFS_FLAGS, 8'h02);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    // Counter written onto compare value on purpose
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h20);
    tick(1);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    // Overflow and its service
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'hFF);
    tick(1);
    rc(tcu8_pkg::OFS_COUNTER_VALUE, 8'h00);
    rc(tcu8_pkg::OFS_FLAGS, 8'h01);
    wb(1, tcu8_pkg::OFS_IRQ_ENABLE, 8'h01);
    global_irq_en_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(ovf_irq_o, 1);
    repeat (8) @(posedge clk_i);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    global_irq_en_i <= 1'b0;
    // Fast PWM: compare buffered until the top of the sequence
    wb(1, 8'h00, ctl(tcu8_pkg::CS_EXT_RISE, tcu8_pkg::WGM_FAST, 0, 0));
    wb(1, tcu8_pkg::OFS_COMPARE_VALUE, 8'h40);
    rc(tcu8_pkg::OFS_COMPARE_VALUE, 8'h40);
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h3E);
    tick(3);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'hFF);
    tick(1);
    wb(1, tcu8_pkg::OFS_FLAGS, 8'h03);
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h3F);
    tick(2);
    rc(tcu8_pkg::OFS_FLAGS, 8'h02);
    // Force strobe, port override and pin direction
    wb(1, tcu8_pkg::OFS_FLAGS, 8'h03);
    wb(1, tcu8_pkg::OFS_PORT, 8'h02);
    wb(1, 8'h00, ctl(tcu8_pkg::CS_STOP, tcu8_pkg::WGM_NORMAL, 3, 0));
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h10);
    wb(1, 8'h00, ctl(tcu8_pkg::CS_STOP, tcu8_pkg::WGM_NORMAL, 3, 1));
    repeat (3) @(posedge clk_i);
    chk(pin_o, 1);
    chk(pin_oe_o, 1);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    rc(tcu8_pkg::OFS_COUNTER_VALUE, 8'h10);
    wb(1, 8'h00, ctl(tcu8_pkg::CS_STOP, tcu8_pkg::WGM_CTC, 3, 0));
    repeat (3) @(posedge clk_i);
    chk(pin_o, 1);
    wb(1, 8'h00, ctl(tcu8_pkg::CS_STOP, tcu8_pkg::WGM_CTC, 0, 0));
    repeat (3) @(posedge clk_i);
    chk(pin_o, 0);
    wb(1, tcu8_pkg::OFS_PORT, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(pin_oe_o, 0);
    // Phase correct: direction turns at max, no overflow there
    wb(1, 8'h00, ctl(tcu8_pkg::CS_EXT_RISE, tcu8_pkg::WGM_PHASE, 0, 0));
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'hFE);
    tick(2);
    rc(tcu8_pkg::OFS_COUNTER_VALUE, 8'hFE);
    tick(1);
    rc(tcu8_pkg::OFS_COUNTER_VALUE, 8'hFD);
    rc(tcu8_pkg::OFS_FLAGS, 8'h00);
    // CTC on falling pin edges: wrap at match, new toggle mode applies
    wb(1, tcu8_pkg::OFS_PORT, 8'h01);
    wb(1, 8'h00, ctl(tcu8_pkg::CS_EXT_FALL, tcu8_pkg::WGM_CTC, 1, 0));
    wb(1, tcu8_pkg::OFS_COMPARE_VALUE, 8'h05);
    wb(1, tcu8_pkg::OFS_COUNTER_VALUE, 8'h04);
    tick(2);
    rc(tcu8_pkg::OFS_COUNTER_VALUE, 8'h00);
    rc(tcu8_pkg::OFS_FLAGS, 8'h02);
    chk(pin_o, 0);
    finish_test();
  end
endmodule // tb
